//--- acp_pointer_ctrl.sv
// Active accumulator pointer with automatic stepping and an AXI4-Lite register slave.
// Functional notes
// - Any reset clears the pointer and its control register to zero.
// - Pointer bits 7:4 and control bits 5:3 always read as zero.
// - The 4-bit pointer picks one of sixteen accumulators for arithmetic and logic.
// - With stepping configured the pointer moves after each completed operation by itself.
// - A move into the pointer during an operation loses to the stepping update.
// - Writing one to control bit 7 forces the pointer to zero.
// - The clear bit drops back to zero by itself and always reads as zero.
// - A clear request beats any stepping update in the same cycle.
// - Direction bit 6 selects increment when zero and decrement when one.
// - Modulus zero disables stepping and makes the direction bit irrelevant.
// - Modulus codes one to three step the low one, two or three bits modulo 2, 4 or 8.
// - Modulus four and the reserved codes five to seven step all four bits modulo 16.
`timescale 1ns/1ps
module acp_pointer_ctrl
  import acp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        op_done,
  input  wire logic        move_valid,
  input  wire logic [3:0]  move_data,
  output logic [3:0]       active_acc_pointer_field,
  output logic [15:0]      acc_select_onehot
);

  // Core state.
  logic [3:0]  active_acc_pointer;
  logic        step_direction;
  logic [2:0]  step_modulus;
  logic [3:0]  next_pointer;
  // Bus state.
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_ok;
  logic        sw_ptr_wr;
  logic        sw_ctl_wr;
  logic        sw_cmd_wr;
  logic        pointer_zero_request;
  logic        step_now;
  logic        move_now;

  // Steps the pointer within the field chosen by the modulus; upper bits are kept.
  function automatic logic [3:0] acp_step(input logic [3:0] ptr, input logic dec,
                                          input logic [2:0] modv);
    logic [3:0] mask;
    logic [3:0] moved;
    mask  = 4'hF;
    moved = dec ? ptr - 4'h1 : ptr + 4'h1;
    if (modv == ACP_MOD_2) begin
      mask = 4'h1;
    end else if (modv == ACP_MOD_4) begin
      mask = 4'h3;
    end else if (modv == ACP_MOD_8) begin
      mask = 4'h7;
    end
    return (ptr & ~mask) | (moved & mask);
  endfunction : acp_step

  // Address decode for the write response only; the read path decodes address bits 7:2 itself.
  function automatic logic acp_mapped(input logic [7:0] addr);
    return (addr == ACP_ADDR_POINTER) || (addr == ACP_ADDR_CONTROL) ||
           (addr == ACP_ADDR_STATUS) || (addr == ACP_ADDR_CMD);
  endfunction : acp_mapped

  // Write channel handshakes: each of address and data is held until both are present.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_ok         = acp_mapped(aw_addr);
  assign sw_ptr_wr     = wr_fire && (aw_addr == ACP_ADDR_POINTER) && w_strb[0];
  assign sw_ctl_wr     = wr_fire && (aw_addr == ACP_ADDR_CONTROL) && w_strb[0];
  assign sw_cmd_wr     = wr_fire && (aw_addr == ACP_ADDR_CMD) && w_strb[0];

  // Catches write address and data in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response, SLVERR for an unmapped address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ACP_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? ACP_RESP_OKAY : ACP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Pointer events from software writes and from the instruction side.
  assign pointer_zero_request = sw_ctl_wr && w_data[ACP_CLR_BIT];
  assign step_now = (op_done || (sw_cmd_wr && w_data[ACP_CMD_OP_BIT])) &&
                    (step_modulus != ACP_MOD_NONE);
  assign move_now = move_valid || (sw_cmd_wr && w_data[ACP_CMD_MOVE_BIT]);

  // Priority: clear, then stepping, then moved data, then a register write.
  always_comb begin
    next_pointer = active_acc_pointer;
    if (pointer_zero_request) begin
      next_pointer = ACP_POINTER_RESET;
    end else if (step_now) begin
      next_pointer = acp_step(active_acc_pointer, step_direction, step_modulus);
    end else if (move_now) begin
      next_pointer = move_valid ? move_data : w_data[7:4];
    end else if (sw_ptr_wr) begin
      next_pointer = w_data[3:0];
    end
  end

  // Pointer register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_acc_pointer <= ACP_POINTER_RESET;
    end else begin
      active_acc_pointer <= next_pointer;
    end
  end

  // Control register; the clear bit is not stored so it reads back as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_direction <= ACP_DIR_RESET;
      step_modulus   <= ACP_MODULUS_RESET;
    end else if (sw_ctl_wr) begin
      step_direction <= w_data[ACP_DIR_BIT];
      step_modulus   <= w_data[ACP_MOD_LSB +: 3];
    end
  end

  // Pointer outputs that choose the active accumulator.
  assign active_acc_pointer_field = active_acc_pointer;
  assign acc_select_onehot = 16'h0001 << active_acc_pointer;

  // Read channel: one cycle from address to data.
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ACP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= ACP_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      if (s_axi_araddr[7:2] == ACP_ADDR_POINTER[7:2]) begin
        s_axi_rdata <= {28'h0000000, active_acc_pointer};
      end else if (s_axi_araddr[7:2] == ACP_ADDR_CONTROL[7:2]) begin
        s_axi_rdata <= {24'h000000, 1'b0, step_direction, 3'h0, step_modulus};
      end else if (s_axi_araddr[7:2] == ACP_ADDR_STATUS[7:2]) begin
        s_axi_rdata <= {15'h0000, acc_select_onehot, 1'b0};
      end else if (s_axi_araddr[7:2] == ACP_ADDR_CMD[7:2]) begin
        s_axi_rdata <= 32'h0000_0000;
      end else begin
        s_axi_rresp <= ACP_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the pointer and control behaviour.
  sequence acp_clear_req_s;
    pointer_zero_request;
  endsequence

  // Register reads accepted for each mapped word.
  sequence acp_rd_ptr_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == ACP_ADDR_POINTER[7:2];
  endsequence

  sequence acp_rd_ctl_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == ACP_ADDR_CONTROL[7:2];
  endsequence

  sequence acp_rd_status_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == ACP_ADDR_STATUS[7:2];
  endsequence

  sequence acp_rd_cmd_s;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == ACP_ADDR_CMD[7:2];
  endsequence

  // A clear request leaves the pointer at zero on the next cycle.
  a_clear_zeroes_pointer: assert property (@(posedge aclk) disable iff (!aresetn)
    acp_clear_req_s |=> active_acc_pointer == 4'h0)
    else $error("Pointer not zero after clear request.");
  // A clear and a step in the same cycle still end at zero.
  a_clear_beats_step: assert property (@(posedge aclk) disable iff (!aresetn)
    acp_clear_req_s and step_now |=> active_acc_pointer == 4'h0)
    else $error("Stepping overrode the clear request.");
  // Reset empties the pointer and the control fields.
  a_reset_clears_all: assert property (@(posedge aclk)
    !aresetn |=> active_acc_pointer == 4'h0 && step_modulus == 3'h0 && !step_direction)
    else $error("Reset did not clear pointer and control.");
  // No mapped word drives the top read bits.
  a_upper_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == ACP_RESP_OKAY |-> s_axi_rdata[31:17] == 15'h0000)
    else $error("Unused read bits not zero.");
  // Modulus zero leaves the pointer alone after an operation.
  a_mod_zero_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    op_done && step_modulus == 3'h0 && !move_valid && !sw_ptr_wr && !sw_cmd_wr
      && !pointer_zero_request |=> $stable(active_acc_pointer))
    else $error("Pointer moved with modulus zero.");
  // A step and a move in one cycle end at the stepped value.
  a_step_beats_move: assert property (@(posedge aclk) disable iff (!aresetn)
    op_done && move_valid && step_modulus != 3'h0 && !pointer_zero_request
      |=> active_acc_pointer == acp_step($past(active_acc_pointer), $past(step_direction),
                                         $past(step_modulus)))
    else $error("Moved value beat the stepping update.");
  // Modulo 16 increment covers the reserved codes as well.
  a_inc_mod16_step: assert property (@(posedge aclk) disable iff (!aresetn)
    op_done && !pointer_zero_request && !step_direction && step_modulus >= 3'h4
      |=> active_acc_pointer == $past(active_acc_pointer) + 4'h1)
    else $error("Modulo 16 increment wrong.");
  // Modulo 4 decrement wraps inside its group of four.
  a_dec_mod4_group: assert property (@(posedge aclk) disable iff (!aresetn)
    op_done && !pointer_zero_request && step_direction && step_modulus == 3'h2
      |=> active_acc_pointer[3:2] == $past(active_acc_pointer[3:2]) &&
          active_acc_pointer[1:0] == $past(active_acc_pointer[1:0]) - 2'h1)
    else $error("Modulo 4 decrement left its group.");
  // Exactly one accumulator is selected, the one the pointer names.
  a_onehot_select: assert property (@(posedge aclk) disable iff (!aresetn)
    acc_select_onehot[active_acc_pointer] && $onehot(acc_select_onehot))
    else $error("Accumulator select does not match pointer.");
  // Modulo 2 stepping toggles only the lowest pointer bit.
  a_op_step_mod2: assert property (@(posedge aclk) disable iff (!aresetn)
    op_done && !pointer_zero_request && step_modulus == 3'h1
      |=> active_acc_pointer == ($past(active_acc_pointer) ^ 4'h1))
    else $error("Modulo 2 step wrong.");
  // Modulo 8 decrement, from an operation or a command, keeps the top bit.
  a_dec_mod8_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    step_now && step_direction && step_modulus == 3'h3 && !pointer_zero_request
      |=> active_acc_pointer[3] == $past(active_acc_pointer[3]) &&
          active_acc_pointer[2:0] == $past(active_acc_pointer[2:0]) - 3'h1)
    else $error("Modulo 8 decrement left its group.");
  // A move with no step in the same cycle loads the moved value.
  a_move_loads: assert property (@(posedge aclk) disable iff (!aresetn)
    move_valid && !step_now && !pointer_zero_request |=> active_acc_pointer == $past(move_data))
    else $error("Moved value not loaded.");

  // Read data of the pointer word carries the pointer and zero above it.
  a_ptr_read_value: assert property (@(posedge aclk) disable iff (!aresetn)
    acp_rd_ptr_s |=> s_axi_rdata == {28'h0000000, $past(active_acc_pointer)})
    else $error("Pointer read data wrong.");
  // Read data of the control word has the clear and reserved bits at zero.
  a_ctl_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    acp_rd_ctl_s |=> s_axi_rdata[31:7] == 25'h0 && s_axi_rdata[5:3] == 3'h0)
    else $error("Control read bits not zero.");
  // The status word mirrors the accumulator select one bit up.
  a_status_mirror: assert property (@(posedge aclk) disable iff (!aresetn)
    acp_rd_status_s |=> s_axi_rdata == {15'h0, $past(acc_select_onehot), 1'b0})
    else $error("Status read does not match select.");
  // The command word is write only and reads as zero.
  a_cmd_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    acp_rd_cmd_s |=> s_axi_rdata == 32'h0000_0000)
    else $error("Command read not zero.");

endmodule : acp_pointer_ctrl

//--- acp_pkg.sv
// Package with register map, field positions and reset values of the accumulator pointer block.
package acp_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] ACP_IDX_POINTER = 8'h00;
  localparam logic [7:0] ACP_IDX_CONTROL = 8'h01;
  localparam logic [7:0] ACP_IDX_STATUS  = 8'h02;
  localparam logic [7:0] ACP_IDX_CMD     = 8'h03;
  // Byte addresses on the bus.
  localparam logic [7:0] ACP_ADDR_POINTER = 8'h00;
  localparam logic [7:0] ACP_ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ACP_ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ACP_ADDR_CMD     = 8'h0C;
  // Reset values.
  localparam logic [3:0] ACP_POINTER_RESET = 4'h0;
  localparam logic [2:0] ACP_MODULUS_RESET = 3'h0;
  localparam logic       ACP_DIR_RESET     = 1'b0;
  // Control register field positions.
  localparam int ACP_CLR_BIT = 7;
  localparam int ACP_DIR_BIT = 6;
  localparam int ACP_MOD_LSB = 0;
  // Command register bit positions.
  localparam int ACP_CMD_OP_BIT   = 0;
  localparam int ACP_CMD_MOVE_BIT = 1;
  // Modulus codes.
  localparam logic [2:0] ACP_MOD_NONE = 3'h0;
  localparam logic [2:0] ACP_MOD_2    = 3'h1;
  localparam logic [2:0] ACP_MOD_4    = 3'h2;
  localparam logic [2:0] ACP_MOD_8    = 3'h3;
  // AXI responses.
  localparam logic [1:0] ACP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACP_RESP_SLVERR = 2'h2;
endpackage : acp_pkg

//--- acp_pointer_ctrl_bench.sv
// Self-checking bench for the accumulator pointer block.
`timescale 1ns/1ps
module acp_pointer_ctrl_bench;
  import acp_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, op_done, move_valid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  move_data, ptr, s_axi_wstrb;
  logic [15:0] onehot;
  int          bad_count, cmp_count;

  // Protection is tied; strobes are driven so a write with byte 0 masked can be tried.
  acp_pointer_ctrl acp_pointer_ctrl_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .op_done,
    .move_valid, .move_data, .active_acc_pointer_field(ptr), .acc_select_onehot(onehot));

  // The clock toggles every half period of 10 ns.
  always #10 aclk = ~aclk;

  // Compares a value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Write with address and data offered together, each released once taken.
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(negedge aclk);
      ta  = s_axi_awvalid && s_axi_awready;
      tw  = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      r   = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!got) begin
      check("write wait", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : axi_write

  // Read with rready held until the data is sampled.
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(negedge aclk);
      ta  = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d   = s_axi_rdata;
      r   = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!got) begin
      check("read wait", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask : axi_read

  // Register write and read helpers that also expect an OKAY answer.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("bresp", r, ACP_RESP_OKAY);
  endtask : wr

  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(what, d, e);
    check("rresp", r, ACP_RESP_OKAY);
  endtask : rd_check

  // One-cycle pulse of the operation and move strobes, then settle.
  task automatic pulse(input logic op, input logic mv, input logic [3:0] d);
    @(posedge aclk);
    op_done    <= op;
    move_valid <= mv;
    move_data  <= d;
    @(posedge aclk);
    op_done    <= 1'b0;
    move_valid <= 1'b0;
    @(negedge aclk);
  endtask : pulse

  // Pointer after one step, upper bits kept outside the stepped field.
  function automatic logic [3:0] stepped(logic [3:0] p, logic dir, logic [2:0] m);
    logic [3:0] mask;
    logic [3:0] s;
    mask = (m == 3'h0) ? 4'h0 : (m == 3'h1) ? 4'h1 : (m == 3'h2) ? 4'h3 :
           (m == 3'h3) ? 4'h7 : 4'hF;
    s = dir ? p - 4'h1 : p + 4'h1;
    return (p & ~mask) | (s & mask);
  endfunction : stepped

  // A reset in mid-run clears both registers.
  task automatic test_reset();
    wr(ACP_ADDR_POINTER, 8'h05);
    wr(ACP_ADDR_CONTROL, 8'h43);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_check("pointer reg", ACP_ADDR_POINTER, 32'h00000000);
    rd_check("control reg", ACP_ADDR_CONTROL, 32'h00000000);
    check("onehot", onehot, 32'h00000001);
  endtask : test_reset

  // Reserved bits read zero and the clear bit empties the pointer.
  task automatic test_reserved();
    wr(ACP_ADDR_POINTER, 8'hFF);
    rd_check("pointer reg", ACP_ADDR_POINTER, 32'h0000000F);
    wr(ACP_ADDR_CONTROL, 8'hFF);
    rd_check("control reg", ACP_ADDR_CONTROL, 32'h00000047);
    check("pointer", ptr, 32'h00000000);
  endtask : test_reserved

  // Every modulus code in both directions, from both ends of the range.
  task automatic test_stepping();
    logic [3:0] p;
    logic [3:0] e;
    for (int i = 0; i < 32; i++) begin
      p = i[4] ? 4'hF : 4'h0;
      e = stepped(p, i[3], i[2:0]);
      wr(ACP_ADDR_POINTER, {4'h0, p});
      wr(ACP_ADDR_CONTROL, {1'b0, i[3], 3'h0, i[2:0]});
      pulse(1'b1, 1'b0, 4'h0);
      check("pointer", ptr, e);
      check("onehot", onehot, 16'h0001 << e);
    end
  endtask : test_stepping

  // A move in the same cycle as a step loses; alone it loads the pointer.
  task automatic test_move();
    wr(ACP_ADDR_CONTROL, 8'h04);
    wr(ACP_ADDR_POINTER, 8'h03);
    pulse(1'b1, 1'b1, 4'h9);
    check("pointer", ptr, 32'h00000004);
    pulse(1'b0, 1'b1, 4'h9);
    check("pointer", ptr, 32'h00000009);
  endtask : test_move

  // Operations run throughout a clearing write; one step follows the clear.
  task automatic test_clear();
    logic [1:0]  r;
    logic [31:0] d;
    wr(ACP_ADDR_CONTROL, 8'h04);
    wr(ACP_ADDR_POINTER, 8'h05);
    op_done <= 1'b1;
    axi_write(ACP_ADDR_CONTROL, 8'h84, r);
    op_done <= 1'b0;
    @(negedge aclk);
    check("pointer", ptr, 32'h00000001);
    axi_write(8'h10, 8'h07, r);
    check("unmapped bresp", r, ACP_RESP_SLVERR);
    axi_read(8'h10, d, r);
    check("unmapped rresp", r, ACP_RESP_SLVERR);
  endtask : test_clear

  // Command strobes, status and command reads, and a write with byte 0 masked.
  task automatic test_command();
    wr(ACP_ADDR_CONTROL, 8'h43);
    wr(ACP_ADDR_POINTER, 8'h08);
    wr(ACP_ADDR_CMD, 8'h01);
    rd_check("cmd step", ACP_ADDR_POINTER, 32'h0000000F);
    wr(ACP_ADDR_CMD, 8'h62);
    rd_check("status reg", ACP_ADDR_STATUS, 32'h00000080);
    rd_check("command reg", ACP_ADDR_CMD, 32'h00000000);
    s_axi_wstrb <= 4'hE;
    wr(ACP_ADDR_POINTER, 8'h02);
    s_axi_wstrb <= 4'hF;
    check("pointer", ptr, 32'h00000006);
  endtask : test_command

  // Main sequence.
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    s_axi_wstrb = 4'hF;
    {s_axi_arvalid, s_axi_rready, op_done, move_valid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, move_data} = 52'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_reserved();
    test_stepping();
    test_move();
    test_command();
    test_clear();
    tally_and_finish();
  end
endmodule : acp_pointer_ctrl_bench
